/* amode_pkg.sv */
// Shared constants and types for the addressing mode and prefix decoder
`default_nettype none
package amode_pkg;
    // Prefix byte values
    localparam logic [7:0] PFX_Y_INDEX    = 8'h90;
    localparam logic [7:0] PFX_INDIRECT_Y = 8'h91;
    localparam logic [7:0] PFX_INDIRECT   = 8'h92;
    // Opcode column and row fields (high nibble row selects operand form)
    localparam int         COL_LSB   = 0;
    localparam int         ROW_LSB   = 4;
    localparam logic [3:0] ROW_REL   = 4'h2;
    localparam logic [3:0] ROW_RMW_D = 4'h3;
    localparam logic [3:0] ROW_RMW_A = 4'h4;
    localparam logic [3:0] ROW_RMW_X = 4'h5;
    localparam logic [3:0] ROW_RMW_S = 4'h6;
    localparam logic [3:0] ROW_RMW_I = 4'h7;
    localparam logic [3:0] ROW_IMM   = 4'hA;
    localparam logic [3:0] ROW_DIR   = 4'hB;
    localparam logic [3:0] ROW_EXT   = 4'hC;
    localparam logic [3:0] ROW_IX2   = 4'hD;
    localparam logic [3:0] ROW_IX1   = 4'hE;
    localparam logic [3:0] ROW_IX    = 4'hF;
    localparam logic [3:0] ROW_BIT   = 4'h1;
    localparam logic [3:0] ROW_BTJ   = 4'h0;
    localparam logic [3:0] ROW_CTRL  = 4'h8;
    localparam logic [3:0] ROW_MISC  = 4'h9;
    // Reset values
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] EA_RESET = 16'h0000;

    typedef enum logic [3:0] {
        AM_INH, AM_IMM, AM_DIR, AM_EXT, AM_IX0, AM_IX1, AM_IX2,
        AM_IND_S, AM_IND_L, AM_IIX_S, AM_IIX_L, AM_REL, AM_REL_IND, AM_BAD
    } amode_type;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'b000_0001,
        ST_OPC   = 7'b000_0010,
        ST_OPB1  = 7'b000_0100,
        ST_OPB2  = 7'b000_1000,
        ST_PTRH  = 7'b001_0000,
        ST_PTRL  = 7'b010_0000,
        ST_DONE  = 7'b100_0000
    } state_type;
endpackage : amode_pkg
`default_nettype wire

/* amode_classify.sv */
// Opcode classifier: mode, operand byte count, legality
`default_nettype none
module amode_classify
    import amode_pkg::*;
(
    input  wire logic [7:0]    opcode,
    input  wire logic [1:0]    prefix,    // 0 none, 1 y, 2 ind, 3 ind_y
    output amode_pkg::amode_type mode,
    output logic [1:0]         nbytes,
    output logic               use_y,
    output logic               legal
);
    logic [3:0] row;
    logic [3:0] col;
    logic       ind;
    assign row = opcode[ROW_LSB +: 4];
    assign col = opcode[COL_LSB +: 4];
    assign ind = (prefix == 2'd2) || (prefix == 2'd3);

    // Mode from opcode row and prefix
    always_comb begin
        mode   = AM_INH;
        nbytes = 2'd0;
        use_y  = (prefix == 2'd1) || (prefix == 2'd3);
        legal  = 1'b1;
        case (row)
            ROW_IMM: begin
                mode   = AM_IMM;
                nbytes = 2'd1;
                legal  = 1'b1;
            end
            ROW_DIR, ROW_RMW_D, ROW_BIT: begin
                mode   = ind ? AM_IND_S : AM_DIR;
                nbytes = 2'd1;
            end
            ROW_EXT: begin
                mode   = ind ? AM_IND_L : AM_EXT;
                nbytes = ind ? 2'd1 : 2'd2;
            end
            ROW_IX2: begin
                mode   = ind ? AM_IIX_L : AM_IX2;
                nbytes = ind ? 2'd1 : 2'd2;
            end
            ROW_IX1, ROW_RMW_S: begin
                mode   = ind ? AM_IIX_S : AM_IX1;
                nbytes = 2'd1;
            end
            ROW_IX, ROW_RMW_I: begin
                mode   = ind ? AM_IIX_S : AM_IX0;
                nbytes = ind ? 2'd1 : 2'd0;
            end
            ROW_REL, ROW_BTJ: begin
                mode   = ind ? AM_REL_IND : AM_REL;
                nbytes = 2'd1;
            end
            ROW_RMW_A, ROW_RMW_X, ROW_CTRL, ROW_MISC: begin
                mode   = AM_INH;
                nbytes = 2'd0;
                legal  = !((row == ROW_CTRL) && (col == 4'hD));
            end
            default: begin
                mode  = AM_BAD;
                legal = 1'b0;
            end
        endcase
    end
endmodule : amode_classify
`default_nettype wire

/* ea_adder.sv */
// Effective address adder: base plus unsigned index or signed offset
`default_nettype none
module ea_adder (
    input  wire logic [15:0] base,
    input  wire logic [7:0]  addend,
    input  wire logic        is_signed,
    output logic [15:0]      sum
);
    logic [15:0] ext;
    // Sign or zero extend the byte, then add modulo 64K
    assign ext = is_signed ? {{8{addend[7]}}, addend} : {8'h00, addend};
    assign sum = base + ext;
endmodule : ea_adder
`default_nettype wire

/* amode_decoder.sv */
// Addressing mode and prefix decoder with effective address generation
`default_nettype none
module amode_decoder
    import amode_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        fetch_valid,   // byte on fetch_byte is valid
    input  wire logic [7:0]  fetch_byte,
    input  wire logic [15:0] fetch_pc,      // address after the fetched byte
    input  wire logic        mem_valid,     // memory read answer valid
    input  wire logic [7:0]  mem_data,
    input  wire logic [7:0]  x_index,
    input  wire logic [7:0]  y_index,
    output logic             fetch_ready,
    output logic             mem_req,
    output logic [15:0]      mem_addr,
    output logic             ea_valid,
    output logic [15:0]      ea_addr,
    output logic [7:0]       opcode_out,
    output logic [3:0]       mode_out,
    output logic             use_y_out,
    output logic             pc_load,
    output logic [15:0]      pc_target,
    output logic             illegal_rst
);
    import amode_pkg::*;

    state_type   state_r;
    logic [1:0]  prefix_r;
    logic [7:0]  opcode_r;
    amode_type   mode_r;
    logic [1:0]  need_r;
    logic        use_y_r;
    logic [7:0]  byte1_r;
    logic [7:0]  byte2_r;
    logic [7:0]  ptrh_r;
    logic [15:0] pc_next_r;
    logic        fetch_ready_r;
    logic        mem_req_r;
    logic [15:0] mem_addr_r;
    logic        ea_valid_r;
    logic [15:0] ea_addr_r;
    logic        pc_load_r;
    logic [15:0] pc_target_r;
    logic        illegal_r;

    amode_type   cls_mode;
    logic [1:0]  cls_nbytes;
    logic        cls_use_y;
    logic        cls_legal;
    logic [1:0]  pfx_nxt;
    logic        is_prefix;
    logic [7:0]  index_val;
    logic [15:0] idx_base;
    logic [15:0] idx_sum;
    logic [15:0] rel_base;
    logic [7:0]  rel_off;
    logic [15:0] rel_sum;

    // Prefix recognition
    always_comb begin
        is_prefix = 1'b1;
        pfx_nxt   = 2'd0;
        case (fetch_byte)
            PFX_Y_INDEX:    pfx_nxt = 2'd1;
            PFX_INDIRECT:   pfx_nxt = 2'd2;
            PFX_INDIRECT_Y: pfx_nxt = 2'd3;
            default:        is_prefix = 1'b0;
        endcase
    end

    amode_classify u_classify (
        .opcode (fetch_byte),
        .prefix (prefix_r),
        .mode   (cls_mode),
        .nbytes (cls_nbytes),
        .use_y  (cls_use_y),
        .legal  (cls_legal)
    );

    // Index base and operand selection for the EA sum
    assign index_val = use_y_r ? y_index : x_index;
    always_comb begin
        idx_base = 16'h0000;
        case (mode_r)
            AM_IX1:   idx_base = {8'h00, byte1_r};
            AM_IX2:   idx_base = {byte1_r, byte2_r};
            AM_IIX_S: idx_base = {8'h00, ptrh_r};
            AM_IIX_L: idx_base = {ptrh_r, byte2_r};
            default:  idx_base = 16'h0000;
        endcase
    end

    ea_adder u_idx_add (
        .base      (idx_base),
        .addend    (index_val),
        .is_signed (1'b0),
        .sum       (idx_sum)
    );

    assign rel_base = pc_next_r;
    assign rel_off  = (mode_r == AM_REL_IND) ? ptrh_r : byte1_r;

    ea_adder u_rel_add (
        .base      (rel_base),
        .addend    (rel_off),
        .is_signed (1'b1),
        .sum       (rel_sum)
    );

    // Sequencer: prefix, opcode, operand bytes, pointer reads, result
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: state_r <= ST_OPC;
                ST_OPC: begin
                    if (fetch_valid && !is_prefix) begin
                        if (!cls_legal)
                            state_r <= ST_DONE;
                        else if (cls_nbytes == 2'd0)
                            state_r <= ST_DONE;
                        else
                            state_r <= ST_OPB1;
                    end
                end
                ST_OPB1: begin
                    if (fetch_valid) begin
                        if (need_r == 2'd2)
                            state_r <= ST_OPB2;
                        else if (mode_r inside {AM_IND_S, AM_IND_L, AM_IIX_S,
                                                AM_IIX_L, AM_REL_IND})
                            state_r <= ST_PTRH;
                        else
                            state_r <= ST_DONE;
                    end
                end
                ST_OPB2: if (fetch_valid) state_r <= ST_DONE;
                ST_PTRH: begin
                    if (mem_valid) begin
                        if (mode_r inside {AM_IND_L, AM_IIX_L})
                            state_r <= ST_PTRL;
                        else
                            state_r <= ST_DONE;
                    end
                end
                ST_PTRL: if (mem_valid) state_r <= ST_DONE;
                ST_DONE: state_r <= ST_OPC;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Prefix and opcode capture
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prefix_r <= 2'd0;
            opcode_r <= 8'h00;
            mode_r   <= AM_INH;
            need_r   <= 2'd0;
            use_y_r  <= 1'b0;
        end else if (state_r == ST_OPC && fetch_valid) begin
            if (is_prefix) begin
                prefix_r <= pfx_nxt;
            end else begin
                opcode_r <= fetch_byte;
                mode_r   <= cls_mode;
                need_r   <= cls_nbytes;
                use_y_r  <= cls_use_y;
            end
        end else if (state_r == ST_DONE) begin
            prefix_r <= 2'd0;
        end
    end

    // Operand bytes and next-instruction address
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            byte1_r   <= 8'h00;
            byte2_r   <= 8'h00;
            pc_next_r <= PC_RESET;
        end else begin
            if (state_r == ST_OPC && fetch_valid)
                pc_next_r <= fetch_pc;
            if (state_r == ST_OPB1 && fetch_valid) begin
                byte1_r   <= fetch_byte;
                pc_next_r <= fetch_pc;
            end
            if (state_r == ST_OPB2 && fetch_valid) begin
                byte2_r   <= fetch_byte;
                pc_next_r <= fetch_pc;
            end
            if (state_r == ST_PTRL && mem_valid)
                byte2_r <= mem_data;
        end
    end

    // Pointer high (or only) byte from memory
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ptrh_r <= 8'h00;
        end else if (state_r == ST_PTRH && mem_valid) begin
            ptrh_r <= mem_data;
        end
    end

    // Memory read requests for pointers and indirect offsets
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mem_req_r  <= 1'b0;
            mem_addr_r <= EA_RESET;
        end else if (state_r == ST_OPB1 && fetch_valid && need_r != 2'd2 &&
                     mode_r inside {AM_IND_S, AM_IND_L, AM_IIX_S, AM_IIX_L, AM_REL_IND}) begin
            mem_req_r  <= 1'b1;
            mem_addr_r <= {8'h00, fetch_byte};
        end else if (state_r == ST_PTRH && mem_valid &&
                     mode_r inside {AM_IND_L, AM_IIX_L}) begin
            mem_req_r  <= 1'b1;
            mem_addr_r <= mem_addr_r + 16'h0001;
        end else if (mem_valid || state_r == ST_DONE) begin
            mem_req_r  <= 1'b0;
        end
    end

    // Results: effective address, relative target, illegal reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ea_valid_r  <= 1'b0;
            ea_addr_r   <= EA_RESET;
            pc_load_r   <= 1'b0;
            pc_target_r <= PC_RESET;
            illegal_r   <= 1'b0;
        end else begin
            ea_valid_r <= 1'b0;
            pc_load_r  <= 1'b0;
            illegal_r  <= state_r == ST_OPC && fetch_valid && !is_prefix &&
                          !cls_legal;
            if (state_r == ST_DONE && mode_r != AM_BAD) begin
                case (mode_r)
                    AM_REL, AM_REL_IND: begin
                        pc_load_r   <= 1'b1;
                        pc_target_r <= rel_sum;
                    end
                    AM_DIR:   begin ea_valid_r <= 1'b1; ea_addr_r <= {8'h00, byte1_r}; end
                    AM_EXT:   begin ea_valid_r <= 1'b1; ea_addr_r <= {byte1_r, byte2_r}; end
                    AM_IND_S: begin ea_valid_r <= 1'b1; ea_addr_r <= {8'h00, ptrh_r}; end
                    AM_IND_L: begin ea_valid_r <= 1'b1; ea_addr_r <= {ptrh_r, byte2_r}; end
                    AM_IX0, AM_IX1, AM_IX2, AM_IIX_S, AM_IIX_L: begin
                        ea_valid_r <= 1'b1;
                        ea_addr_r  <= idx_sum;
                    end
                    default: ea_valid_r <= 1'b0;
                endcase
            end
        end
    end

    // Fetch ready from a flop: high in opcode and operand fetch states only
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fetch_ready_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE, ST_DONE: fetch_ready_r <= 1'b1;
                ST_OPC: begin
                    if (fetch_valid && !is_prefix && (!cls_legal || cls_nbytes == 2'd0))
                        fetch_ready_r <= 1'b0;
                end
                ST_OPB1: if (fetch_valid && need_r != 2'd2) fetch_ready_r <= 1'b0;
                ST_OPB2: if (fetch_valid) fetch_ready_r <= 1'b0;
                default: fetch_ready_r <= 1'b0;
            endcase
        end
    end

    assign fetch_ready = fetch_ready_r;
    assign mem_req     = mem_req_r;
    assign mem_addr    = mem_addr_r;
    assign ea_valid    = ea_valid_r;
    assign ea_addr     = ea_addr_r;
    assign opcode_out  = opcode_r;
    assign mode_out    = mode_r;
    assign use_y_out   = use_y_r;
    assign pc_load     = pc_load_r;
    assign pc_target   = pc_target_r;
    assign illegal_rst = illegal_r;

    // Illegal byte raises reset request exactly one cycle later, no result
    chk_illegal_reset: assert property (@(posedge sys_clk) disable iff (rst)
        (state_r == ST_OPC && fetch_valid && !is_prefix && !cls_legal)
        |=> (illegal_rst && !ea_valid && !pc_load))
        else $error("illegal opcode did not raise reset");
    // Prefix byte never raises reset
    chk_prefix_legal: assert property (@(posedge sys_clk) disable iff (rst)
        (state_r == ST_OPC && fetch_valid && is_prefix) |=> !illegal_rst)
        else $error("prefix raised reset");
    // Short direct address sits in page zero
    chk_short_direct: assert property (@(posedge sys_clk) disable iff (rst)
        (ea_valid && mode_r == AM_DIR) |-> ea_addr[15:8] == 8'h00)
        else $error("short direct outside page zero");
    // Short indexed stays within 1FE
    chk_short_index: assert property (@(posedge sys_clk) disable iff (rst)
        (ea_valid && mode_r inside {AM_IX1, AM_IIX_S}) |-> ea_addr <= 16'h01FE)
        else $error("short indexed beyond 1FE");
    // No offset indexed equals the index register
    chk_no_offset: assert property (@(posedge sys_clk) disable iff (rst)
        (ea_valid && mode_r == AM_IX0) |-> ea_addr == {8'h00, $past(index_val)})
        else $error("no offset address differs from index");
    // Relative target within -128..+127 of next instruction
    chk_rel_reach: assert property (@(posedge sys_clk) disable iff (rst)
        pc_load |-> (pc_target - pc_next_r + 16'h0080) <= 16'h00FF)
        else $error("relative target out of reach");
    // Registered ready matches the fetch states
    chk_ready_state: assert property (@(posedge sys_clk) disable iff (rst)
        fetch_ready == (state_r inside {ST_OPC, ST_OPB1, ST_OPB2}))
        else $error("fetch ready out of step with state");
    // Result pulse lasts one cycle: no result in the cycle after a result
    chk_result_pulse: assert property (@(posedge sys_clk) disable iff (rst)
        (ea_valid || pc_load) |=> !(ea_valid || pc_load))
        else $error("result pulse longer than one cycle");
    // Short indirect address sits in page zero
    chk_short_indirect: assert property (@(posedge sys_clk) disable iff (rst)
        (ea_valid && mode_r == AM_IND_S) |-> ea_addr[15:8] == 8'h00)
        else $error("short indirect outside page zero");
    // Prefix byte is kept for the opcode that follows it
    sequence seq_prefix_taken;
        state_r == ST_OPC && fetch_valid && is_prefix;
    endsequence
    chk_prefix_held: assert property (@(posedge sys_clk) disable iff (rst)
        seq_prefix_taken |=> (state_r == ST_OPC && prefix_r == $past(pfx_nxt)))
        else $error("prefix not held for opcode");
    // Word pointer: high byte answered, low byte asked at the next address
    sequence seq_ptr_high_taken;
        state_r == ST_PTRH && mem_valid && mode_r inside {AM_IND_L, AM_IIX_L};
    endsequence
    sequence seq_ptr_low_asked;
        state_r == ST_PTRL && mem_req && mem_addr == $past(mem_addr) + 16'h0001;
    endsequence
    chk_word_pointer: assert property (@(posedge sys_clk) disable iff (rst)
        seq_ptr_high_taken |=> seq_ptr_low_asked)
        else $error("word pointer low byte not requested");
endmodule : amode_decoder
`default_nettype wire

/* fetch_mem_model.sv */
// Fetch stage and pointer memory read port model facing the decoder
`default_nettype none
module fetch_mem_model (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        fetch_ready,
    input  wire logic        mem_req,
    input  wire logic [15:0] mem_addr,
    output logic             fetch_valid,
    output logic [7:0]       fetch_byte,
    output logic [15:0]      fetch_pc,
    output logic             mem_valid,
    output logic [7:0]       mem_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  q[$];
    logic [15:0] next_pc;
    int          gap_seed = 24507;
    int          mem_seed = 24508;

    // Memory contents follow from the address
    function automatic logic [7:0] mem_val(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction : mem_val

    // Byte stream held until taken, random gaps, inverted when idle
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fetch_valid <= 1'b0;
            fetch_byte  <= 8'h00;
            fetch_pc    <= 16'h0000;
            next_pc = 16'h0100;
        end else if (!fetch_valid || fetch_ready) begin
            if (q.size() > 0 && ($random(gap_seed) & 3) != 0) begin
                fetch_valid <= 1'b1;
                fetch_byte  <= q.pop_front();
                next_pc = next_pc + 16'h0001;
                fetch_pc    <= next_pc;
            end else begin
                fetch_valid <= 1'b0;
                fetch_byte  <= ~fetch_byte;
                fetch_pc    <= ~fetch_pc;
            end
        end
    end

    // Pointer reads answered promptly or late, one pulse per byte
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mem_valid <= 1'b0;
            mem_data  <= 8'h00;
        end else if (mem_req && !mem_valid && ($random(mem_seed) & 1) != 0) begin
            mem_valid <= 1'b1;
            mem_data  <= mem_val(mem_addr);
        end else begin
            mem_valid <= 1'b0;
            mem_data  <= ~mem_data;
        end
    end
endmodule : fetch_mem_model
`default_nettype wire

/* addressing_mode_prefix_decoder_test.sv */
// Self-checking testbench for the addressing mode and prefix decoder
`default_nettype none
module addressing_mode_prefix_decoder_test
    import amode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [7:0]  x_index = 8'h00;
    logic [7:0]  y_index = 8'h00;
    logic        fetch_valid, fetch_ready, mem_req, mem_valid;
    logic        ea_valid, use_y_out, pc_load, illegal_rst;
    logic [7:0]  fetch_byte, mem_data, opcode_out;
    logic [15:0] fetch_pc, mem_addr, ea_addr, pc_target, pc_next;
    logic [3:0]  mode_out;
    int          num_errors = 0;
    int          tests_run  = 0;
    int          seed       = 24507;
    int          cyc        = 0;
    int          take_cyc   = 0;

    always #10 sys_clk = ~sys_clk;

    // Edge count and edge of the latest byte taken
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (fetch_valid && fetch_ready) take_cyc <= cyc;
    end

    amode_decoder amode_decoder_i (
        .sys_clk(sys_clk), .rst(rst), .fetch_valid(fetch_valid), .fetch_byte(fetch_byte),
        .fetch_pc(fetch_pc), .mem_valid(mem_valid), .mem_data(mem_data), .x_index(x_index),
        .y_index(y_index), .fetch_ready(fetch_ready), .mem_req(mem_req), .mem_addr(mem_addr),
        .ea_valid(ea_valid), .ea_addr(ea_addr), .opcode_out(opcode_out), .mode_out(mode_out),
        .use_y_out(use_y_out), .pc_load(pc_load), .pc_target(pc_target),
        .illegal_rst(illegal_rst)
    );

    fetch_mem_model fetch_mem_model_i (
        .sys_clk(sys_clk), .rst(rst), .fetch_ready(fetch_ready), .mem_req(mem_req),
        .mem_addr(mem_addr), .fetch_valid(fetch_valid), .fetch_byte(fetch_byte),
        .fetch_pc(fetch_pc), .mem_valid(mem_valid), .mem_data(mem_data)
    );

    // Expected memory byte and zero extension
    function automatic logic [7:0] mv(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction : mv
    function automatic logic [15:0] z(input logic [7:0] b);
        return {8'h00, b};
    endfunction : z

    task automatic tally_and_finish();
        $display("Checks run %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic compare_addr(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : compare_addr

    task automatic compare_mode(input logic [3:0] got, input logic [3:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t mode got=%h exp=%h", $time, got, exp);
        end
    endtask : compare_mode

    task automatic compare_flag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t flag got=%h exp=%h", $time, got, exp);
        end
    endtask : compare_flag

    task automatic do_reset();
        rst <= 1'b1;
        @(posedge sys_clk);
        fetch_mem_model_i.q.delete();
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        pc_next = 16'h0100;
        repeat (2) @(posedge sys_clk);
    endtask : do_reset

    task automatic issue(input logic [7:0] b[$]);
        foreach (b[i]) fetch_mem_model_i.q.push_back(b[i]);
        pc_next = pc_next + 16'(b.size());
    endtask : issue

    // Bounded wait: 0 address result, 1 branch target, 2 reset request
    task automatic await(input int which, output logic [15:0] val, output logic [3:0] md);
        for (int n = 0; n < 80; n++) begin
            @(posedge sys_clk);
            md = mode_out;
            if (which == 0 && ea_valid === 1'b1) begin val = ea_addr; return; end
            if (which == 1 && pc_load === 1'b1) begin val = pc_target; return; end
            if (which == 2 && illegal_rst === 1'b1) begin val = 16'(cyc - take_cyc); return; end
        end
        num_errors++;
        $display("[ERR] t=%0t wait exp=%h got=%h", $time, 1'b1, 1'b0);
        tally_and_finish();
    endtask : await

    task automatic run(input logic [7:0] b[$], input bit rel, input logic [15:0] exp_in,
                       input logic [3:0] exp_md);
        logic [15:0] got;
        logic [15:0] exp;
        logic [3:0]  md;
        logic [7:0]  opc;
        exp = exp_in;
        opc = (b[0] inside {PFX_Y_INDEX, PFX_INDIRECT, PFX_INDIRECT_Y}) ? b[1] : b[0];
        issue(b);
        if (rel) exp = pc_next + {{8{exp_in[7]}}, exp_in[7:0]};
        await(rel ? 1 : 0, got, md);
        compare_addr(got, exp);
        compare_mode(md, exp_md);
        compare_addr(z(opcode_out), z(opc));
        compare_flag(use_y_out, b[0] == PFX_Y_INDEX || b[0] == PFX_INDIRECT_Y);
    endtask : run

    // Prefix and opcode pair that must not raise the reset request
    task automatic no_reset(input logic [7:0] b[$]);
        logic seen;
        seen = 1'b0;
        issue(b);
        repeat (12) begin
            @(posedge sys_clk);
            seen = seen | illegal_rst;
        end
        compare_flag(seen, 1'b0);
        do_reset();
    endtask : no_reset

    initial begin
        logic [7:0]  b1, b2, x, y;
        logic [15:0] p, w;
        logic [3:0]  md;
        do_reset();
        for (int k = 0; k < 8; k++) begin
            x  = (k == 0) ? 8'hFF : 8'($random(seed));
            y  = (k == 0) ? 8'hFF : 8'($random(seed));
            b1 = (k == 0) ? 8'hFF : 8'($random(seed));
            b2 = (k == 0) ? 8'hFF : 8'($random(seed));
            x_index <= x;
            y_index <= y;
            @(posedge sys_clk);
            p = z(mv(z(b1)));
            w = {mv(z(b1)), mv(z(b1) + 16'h0001)};
            run({8'hB6, b1}, 0, z(b1), AM_DIR);
            run({8'h3A, b1}, 0, z(b1), AM_DIR);
            run({8'hC6, b1, b2}, 0, {b1, b2}, AM_EXT);
            run({8'hF6}, 0, z(x), AM_IX0);
            run({8'h90, 8'hF6}, 0, z(y), AM_IX0);
            run({8'hE6, b1}, 0, z(b1) + z(x), AM_IX1);
            run({8'h90, 8'hE6, b1}, 0, z(b1) + z(y), AM_IX1);
            run({8'hD6, b1, b2}, 0, {b1, b2} + z(x), AM_IX2);
            run({8'h90, 8'hD6, b1, b2}, 0, {b1, b2} + z(y), AM_IX2);
            run({8'h92, 8'hB6, b1}, 0, p, AM_IND_S);
            run({8'h92, 8'hF6, b1}, 0, p + z(x), AM_IIX_S);
            run({8'h92, 8'hC6, b1}, 0, w, AM_IND_L);
            run({8'h92, 8'hE6, b1}, 0, p + z(x), AM_IIX_S);
            run({8'h91, 8'hE6, b1}, 0, p + z(y), AM_IIX_S);
            run({8'h92, 8'hD6, b1}, 0, w + z(x), AM_IIX_L);
            run({8'h20, b1}, 1, z(b1), AM_REL);
            run({8'h92, 8'h20, b1}, 1, p, AM_REL_IND);
        end
        run({8'h20, 8'h80}, 1, 16'h0080, AM_REL);
        run({8'h20, 8'h7F}, 1, 16'h007F, AM_REL);
        issue({8'h8D});
        await(2, p, md);
        compare_addr(p, 16'h0001);
        do_reset();
        no_reset({8'h91, 8'hB6, 8'h10});
        no_reset({8'h90, 8'hA6, 8'h10});
        no_reset({8'h92, 8'hAD, 8'h10});
        tally_and_finish();
    end
endmodule : addressing_mode_prefix_decoder_test
`default_nettype wire
